/* File: asf_pkg.sv */
// package for the converter status-flag bank
package asf_pkg;
	localparam logic [4:0] ADDR_STATUS_A = 5'h09;
	localparam logic [4:0] ADDR_STATUS_B = 5'h0F;
	localparam logic [4:0] ADDR_LOCK = 5'h0A;
	localparam logic [7:0] LOCK_ON_CODE = 8'hCA;
	localparam logic [7:0] LOCK_OFF_CODE = 8'h9C;
	localparam int BIT_RESET_ON = 0;
	localparam int BIT_CRC_CHANGED = 1;
	localparam int BIT_LOCK_ACTIVE = 2;
	localparam int BIT_SAMPLES_MISSED = 3;
	localparam int READY_LOW_CYCLES = 64;
	localparam int RESET_HOLD_CYCLES = 16;
endpackage : asf_pkg

/* File: asf_status_flags.sv */
// status flags, lock register and data-ready pulse of the converter
`timescale 1ns/1ps
`default_nettype none
// Operation
// [RL1] set checksum-changed flag, bit 1 of status A, whenever checksum changes
// [RL2] any status A read clears checksum-changed flag
// [RL3] writing 0xCA to lock register sets lock-active flag, bit 2
// [RL4] status A read clears lock-active; re-set next output cycle while locked
// [RL5] reset-in-progress flag, bit 0, clears at end of reset period
// [RL6] samples-missed flag, status B bit 3, sets if samples unread in cycle
// [RL7] status B read clears samples-missed flag
// [RL8] both status words readable singly; status A also in burst read
// [RL9] data-ready goes low exactly 64 input clocks per new sample set
// [RL10] host starts reading samples at the falling data-ready edge
// [RL11] supplied input clock stays between 3.6 and 4.21 MHz, nominal 4.096
// [RL12] writing 0x9C to lock register disables protection, default disabled
// [RL13] host polls status A until reset-in-progress reads zero
// [RL14] a set coinciding with its clearing read wins
module asf_status_flags
	import asf_pkg::*;
#(
	parameter int READY_LOW = READY_LOW_CYCLES,
	parameter int RESET_HOLD = RESET_HOLD_CYCLES
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic reg_burst_rd,
	input wire logic [4:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] config_crc,
	input wire logic output_cycle,
	input wire logic current_sample_rd,
	input wire logic voltage_one_sample_rd,
	input wire logic voltage_two_sample_rd,
	output logic lock_enabled,
	output logic clock_out_sample_ready_n
);
	logic rd_a;
	logic rd_b;
	logic reset_on;
	logic crc_changed;
	logic config_lock_active;
	logic samples_missed;
	logic [15:0] crc_prev;
	logic crc_seen;
	logic [2:0] samples_read;
	logic [7:0] ready_cnt;
	logic [7:0] hold_cnt;
	logic crc_event;
	logic lock_event;
	logic miss_event;
	logic [7:0] status_a;
	logic [7:0] status_b;
	logic [7:0] low_run;

	// burst read of status A clears like a single read
	assign rd_a = (reg_rd && reg_addr == ADDR_STATUS_A) || reg_burst_rd; // [RL8]
	assign rd_b = reg_rd && reg_addr == ADDR_STATUS_B; // [RL8]
	assign crc_event = crc_seen && (config_crc != crc_prev);
	assign lock_event = (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_ON_CODE)
		|| (lock_enabled && output_cycle);
	assign miss_event = output_cycle && (samples_read != 3'h7);

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			hold_cnt <= 8'h00;
			reset_on <= 1'b1;
		end
		else if (hold_cnt != 8'(RESET_HOLD))
			hold_cnt <= hold_cnt + 8'h01;
		else
			reset_on <= 1'b0; // [RL5]
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			crc_prev <= 16'h0000;
			crc_seen <= 1'b0;
		end
		else
		begin
			crc_prev <= config_crc;
			crc_seen <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			crc_changed <= 1'b0;
		else if (crc_event)
			crc_changed <= 1'b1; // [RL1] [RL14]
		else if (rd_a)
			crc_changed <= 1'b0; // [RL2]
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			lock_enabled <= 1'b0; // [RL12]
		else if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_ON_CODE)
			lock_enabled <= 1'b1; // [RL3]
		else if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_OFF_CODE)
			lock_enabled <= 1'b0; // [RL12]
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			config_lock_active <= 1'b0;
		else if (lock_event)
			config_lock_active <= 1'b1; // [RL3] [RL4] [RL14]
		else if (rd_a)
			config_lock_active <= 1'b0; // [RL4]
	end

	// tracks which of the three samples were read since the last output cycle
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			samples_read <= 3'h7;
		else if (output_cycle)
			samples_read <= 3'h0;
		else
			samples_read <= samples_read
				| {voltage_two_sample_rd, voltage_one_sample_rd, current_sample_rd};
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			samples_missed <= 1'b0;
		else if (miss_event)
			samples_missed <= 1'b1; // [RL6] [RL14]
		else if (rd_b)
			samples_missed <= 1'b0; // [RL7]
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			ready_cnt <= 8'h00;
		else if (output_cycle)
			ready_cnt <= 8'(READY_LOW); // [RL9]
		else if (ready_cnt != 8'h00)
			ready_cnt <= ready_cnt - 8'h01;
	end
	assign clock_out_sample_ready_n = (ready_cnt == 8'h00); // [RL9]

	// field positions come from the package so both words stay in step with the map
	always_comb
	begin
		status_a = 8'h00;
		status_a[BIT_RESET_ON] = reset_on; // [RL5]
		status_a[BIT_CRC_CHANGED] = crc_changed; // [RL1]
		status_a[BIT_LOCK_ACTIVE] = config_lock_active; // [RL3]
		status_b = 8'h00;
		status_b[BIT_SAMPLES_MISSED] = samples_missed; // [RL6]
	end

	// checker helper: low cycles of the running pulse; a new set restarts it
	always_ff @(posedge ref_clk)
	begin
		if (rst || output_cycle || clock_out_sample_ready_n)
			low_run <= 8'h00;
		else if (low_run != 8'hFF)
			low_run <= low_run + 8'h01;
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (rd_a)
			reg_rdata <= status_a; // [RL8]
		else if (rd_b)
			reg_rdata <= status_b; // [RL8]
		else
			reg_rdata <= 8'h00;
	end

	sequence lock_on_write_s;
		reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_ON_CODE;
	endsequence

	sequence lock_off_write_s;
		reg_wr && reg_addr == ADDR_LOCK && reg_wdata == LOCK_OFF_CODE;
	endsequence

	chk_ready_width: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
		output_cycle |=> !clock_out_sample_ready_n [*8])
		else $error("data-ready low too short");
	chk_ready_release: assert property (@(posedge ref_clk) disable iff (rst) // [RL9]
		$rose(clock_out_sample_ready_n) |-> low_run == 8'(READY_LOW))
		else $error("data-ready pulse length wrong");
	chk_crc_set: assert property (@(posedge ref_clk) disable iff (rst) // [RL1]
		crc_event |=> crc_changed)
		else $error("checksum flag not set");
	chk_crc_clear: assert property (@(posedge ref_clk) disable iff (rst) // [RL2]
		rd_a && !crc_event |=> !crc_changed)
		else $error("checksum flag not cleared");
	chk_lock_set: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
		lock_enabled && output_cycle |=> config_lock_active)
		else $error("lock flag not re-set");
	chk_lock_clear: assert property (@(posedge ref_clk) disable iff (rst) // [RL4]
		rd_a && !lock_event |=> !config_lock_active)
		else $error("lock flag not cleared");
	chk_miss_set: assert property (@(posedge ref_clk) disable iff (rst) // [RL6]
		miss_event |=> samples_missed)
		else $error("missed flag not set");
	chk_miss_clear: assert property (@(posedge ref_clk) disable iff (rst) // [RL7]
		rd_b && !miss_event |=> !samples_missed)
		else $error("missed flag not cleared");
	chk_unlock_code: assert property (@(posedge ref_clk) disable iff (rst) // [RL12]
		lock_off_write_s |=> !lock_enabled)
		else $error("protection not disabled");
	chk_lock_on: assert property (@(posedge ref_clk) disable iff (rst) // [RL3]
		lock_on_write_s |=> lock_enabled && config_lock_active)
		else $error("protection not enabled");
	chk_reset_done: assert property (@(posedge ref_clk) disable iff (rst) // [RL5]
		!reset_on |=> !reset_on)
		else $error("reset flag set again");
	chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst) // [RL8]
		!rd_a && !rd_b |=> reg_rdata == 8'h00)
		else $error("read data without read");
endmodule : asf_status_flags
`default_nettype wire

/* File: asf_host_model.sv */
// host model issuing register strobes toward the flag bank
`timescale 1ns/1ps
`default_nettype none
module asf_host_model
(
	input wire logic ref_clk,
	output logic reg_rd,
	output logic reg_burst_rd,
	output logic [4:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata
);
	initial {reg_rd, reg_burst_rd, reg_addr, reg_wr, reg_wdata} = '0;
	// kind 0 write, 1 read, 2 burst; address flipped after so stale values never pass
	task automatic access(input logic [1:0] kind, input logic [4:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		{reg_burst_rd, reg_rd, reg_wr} <= {kind == 2'h2, kind == 2'h1, kind == 2'h0};
		@(negedge ref_clk);
		{reg_burst_rd, reg_rd, reg_wr} <= 3'h0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : access
endmodule : asf_host_model
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the status-flag bank with its host model
`timescale 1ns/1ps
`default_nettype none
module tb;
	import asf_pkg::*;
	logic ref_clk = 0, rst = 1, oc = 0, s0 = 0, s1 = 0, s2 = 0, pend = 0;
	logic [15:0] crc = 16'h0013;
	wire logic hrd, brd, wr, lock, rdy_n;
	wire logic [4:0] addr;
	wire logic [7:0] wd, rdata;
	int failures = 0, samples_checked = 0, cyc = 0, n = 0;
	logic [7:0] exp_q[$];
	always #2.5 ref_clk = ~ref_clk; // bench rate; flags depend on cycle counts only
	asf_host_model host (.ref_clk(ref_clk), .reg_rd(hrd), .reg_burst_rd(brd), .reg_addr(addr),
		.reg_wr(wr), .reg_wdata(wd));
	asf_status_flags #(.RESET_HOLD(2)) DUT (.ref_clk(ref_clk), .rst(rst), .reg_rd(hrd),
		.reg_burst_rd(brd), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdata),
		.config_crc(crc), .output_cycle(oc), .current_sample_rd(s0), .voltage_one_sample_rd(s1),
		.voltage_two_sample_rd(s2), .lock_enabled(lock), .clock_out_sample_ready_n(rdy_n));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			failures++;
			$display("BAD %0t got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic give_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic rd_chk(input logic [4:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		host.access(2'h1, a, 8'h00);
	endtask : rd_chk
	task automatic tick(input logic sampled);
		@(negedge ref_clk) oc <= 1;
		@(negedge ref_clk) oc <= 0;
		check({7'h00, rdy_n}, 8'h00);
		{s0, s1, s2} <= {3{sampled}};
		@(negedge ref_clk) {s0, s1, s2} <= 3'h0;
	endtask : tick
	always @(posedge ref_clk) pend <= hrd | brd;
	always @(negedge ref_clk)
		if (pend)
			check(rdata, exp_q.pop_front());
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (5) @(negedge ref_clk);
		rst = 0;
		rd_chk(ADDR_STATUS_A, 8'h01);
		repeat (4) @(negedge ref_clk);
		rd_chk(ADDR_STATUS_A, 8'h00);
		tick(1);
		tick(0);
		rd_chk(ADDR_STATUS_B, 8'h00);
		tick(0);
		rd_chk(ADDR_STATUS_B, 8'h08);
		rd_chk(ADDR_STATUS_B, 8'h00);
		@(negedge ref_clk) crc <= lfsr(crc);
		rd_chk(ADDR_STATUS_A, 8'h02);
		rd_chk(ADDR_STATUS_A, 8'h00);
		exp_q.push_back(8'h00);
		fork
			host.access(2'h2, ADDR_STATUS_A, 8'h00);
			@(negedge ref_clk) crc <= lfsr(crc);
		join
		rd_chk(ADDR_STATUS_A, 8'h02);
		host.access(2'h0, ADDR_LOCK, LOCK_ON_CODE);
		check({7'h00, lock}, 8'h01);
		rd_chk(ADDR_STATUS_A, 8'h04);
		rd_chk(ADDR_STATUS_A, 8'h00);
		tick(0);
		rd_chk(ADDR_STATUS_A, 8'h04);
		host.access(2'h0, ADDR_LOCK, LOCK_OFF_CODE);
		tick(0);
		rd_chk(ADDR_STATUS_A, 8'h00);
		@(negedge ref_clk) oc <= 1;
		@(negedge ref_clk) oc <= 0;
		repeat (2) if (rdy_n) @(negedge ref_clk);
		while (rdy_n === 1'b0 && n < 99)
		begin
			n++;
			@(negedge ref_clk);
		end
		check(8'(n), 8'h40);
		host.access(2'h0, ADDR_LOCK, LOCK_ON_CODE);
		@(negedge ref_clk) rst = 1;
		repeat (2) @(negedge ref_clk);
		rst = 0;
		check({7'h00, lock}, 8'h00);
		rd_chk(ADDR_STATUS_A, 8'h01);
		rd_chk(ADDR_STATUS_B, 8'h00);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
